// [arb_table_tracker.sv]
// coherency tracker for the port arbitration table of virtual channel 0
`timescale 1ns/1ns
module arb_table_tracker
   import vc0_port_arb_pkg::*;
(
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   input  wire logic i_clk_en,
   // events
   input  wire logic i_table_write,
   input  wire logic i_load_request,
   input  wire logic i_load_done,
   // state
   output logic      o_table_status
);

   table_state_e state;
   table_state_e next_state;

   always_comb begin
      next_state = state;
      case (state)
         TBL_CLEAN: begin
            if (i_table_write) begin
               next_state = TBL_DIRTY;                                  // [RL5]
            end
         end
         TBL_DIRTY: begin
            // a load request moves on even if a write lands alongside it
            if (i_load_request) begin
               next_state = TBL_LOADING;                                // [RL6]
            end
         end
         TBL_LOADING: begin
            // a write during the load makes the loaded copy stale again: set wins
            if (i_table_write) begin
               next_state = TBL_DIRTY;                                  // [RL5]
            end else if (i_load_done) begin
               next_state = TBL_CLEAN;                                  // [RL6]
            end
         end
         default: begin
            next_state = TBL_DIRTY;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= TBL_CLEAN;
      end else if (i_clk_en) begin
         state <= next_state;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_table_status <= 1'b0;
      end else if (i_clk_en) begin
         o_table_status <= (next_state != TBL_CLEAN);                   // [RL5] [RL6]
      end
   end

endmodule // arb_table_tracker

// [tb.sv]
// self-checking bench for the vc0 arbitration control and status block
`timescale 1ns/1ns
module tb
   import vc0_port_arb_pkg::*;
   ;
   localparam logic [11:0] CTL = OFF_CONTROL[11:0];
   localparam logic [11:0] STS = OFF_STATUS[11:0];
   logic        i_clk = '0, i_reset_n = '0, i_clk_en = '1;
   logic [11:0] i_axi_awaddr = '0, i_axi_araddr = '0;
   logic [31:0] i_axi_wdata = '0, o_axi_rdata, rdat;
   logic [3:0]  i_axi_wstrb = 4'hf;
   logic        i_axi_awvalid = '0, i_axi_wvalid = '0, i_axi_bready = '0;
   logic        i_axi_arvalid = '0, i_axi_rready = '0, i_table_write = '0, i_load_done = '0;
   logic        o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
   logic [1:0]  o_axi_bresp, o_axi_rresp, resp;
   logic        o_load_request, o_arb_table_status, o_arb_table_status_valid;
   logic [2:0]  o_arb_scheme_select;
   int          checks = 0, miscompares = 0, cyc = 0, loads = 0;
   // scheme 1 consults the table so the valid output is exercised
   vc0_port_arb_ctl_status #(.TABLE_SCHEMES(8'h02)) vc0_port_arb_ctl_status_inst (
      .i_clk, .i_reset_n, .i_clk_en, .i_axi_awaddr, .i_axi_awvalid, .o_axi_awready,
      .i_axi_wdata, .i_axi_wstrb, .i_axi_wvalid, .o_axi_wready, .o_axi_bresp, .o_axi_bvalid,
      .i_axi_bready, .i_axi_araddr, .i_axi_arvalid, .o_axi_arready, .o_axi_rdata,
      .o_axi_rresp, .o_axi_rvalid, .i_axi_rready, .i_table_write, .i_load_done,
      .o_load_request, .o_arb_scheme_select, .o_arb_table_status, .o_arb_table_status_valid);
   always #5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      loads <= loads + o_load_request;
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares++;
         summarize;
      end
   end
   task summarize;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // both channels offered together, each released on its own ready
   task wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_axi_awaddr <= a;
      i_axi_wdata <= d;
      i_axi_awvalid <= '1;
      i_axi_wvalid <= '1;
      i_axi_bready <= '1;
      do begin
         @(posedge i_clk);
         if (o_axi_awready) i_axi_awvalid <= '0;
         if (o_axi_wready) i_axi_wvalid <= '0;
      end while (!o_axi_bvalid);
      resp = o_axi_bresp;
      i_axi_bready <= '0;
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] e);
      @(posedge i_clk);
      i_axi_araddr <= a;
      i_axi_arvalid <= '1;
      i_axi_rready <= '1;
      do begin
         @(posedge i_clk);
         if (o_axi_arready) i_axi_arvalid <= '0;
      end while (!o_axi_rvalid);
      rdat = o_axi_rdata;
      resp = o_axi_rresp;
      i_axi_rready <= '0;
      chk(rdat, e);
   endtask
   task tw_pulse;
      @(posedge i_clk);
      i_table_write <= '1;
      @(posedge i_clk);
      i_table_write <= '0;
   endtask
   task done_pulse;
      @(posedge i_clk);
      i_load_done <= '1;
      @(posedge i_clk);
      i_load_done <= '0;
   endtask
   task t_map;
      rdc(CTL, 32'h8000_0000);
      rdc(STS, '0);
      rdc(OFF_CAPABILITY[11:0], 32'h0000_0001);
      for (int s = 0; s < 8; s++) begin
         wr(CTL, ~(32'h7 << 17) | (s << 17));
         rdc(CTL, 32'h8000_0000 | (s << 17));
         chk(o_arb_scheme_select, s[2:0]);
         chk(o_arb_table_status_valid, s == 1);
      end
      wr(CTL, '0);
      chk(resp, RESP_OKAY);
      wr(STS, '1);
      chk(resp, RESP_OKAY);
      rdc(STS, '0);
      chk(resp, RESP_OKAY);
      wr(12'h300, '1);
      chk(resp, RESP_SLVERR);
      rdc(12'h300, '0);
      chk(resp, RESP_SLVERR);
      // lane 2 strobe off: neither the selector nor the load bit may be taken
      i_axi_wstrb <= 4'hb;
      wr(CTL, 32'h000f_0000);
      i_axi_wstrb <= 4'hf;
      rdc(CTL, 32'h8000_0000);
      chk(loads, 8);
      $display("map test done");
   endtask
   task t_table;
      tw_pulse;
      rdc(STS, 32'h0001_0000);
      done_pulse;
      rdc(STS, 32'h0001_0000);
      wr(CTL, 32'h0001_0000);
      rdc(STS, 32'h0001_0000);
      done_pulse;
      rdc(STS, '0);
      // a table write landing with load done must leave the flag set
      tw_pulse;
      wr(CTL, 32'h0001_0000);
      @(posedge i_clk);
      i_table_write <= '1;
      i_load_done <= '1;
      @(posedge i_clk);
      i_table_write <= '0;
      i_load_done <= '0;
      rdc(STS, 32'h0001_0000);
      wr(CTL, 32'h0001_0000);
      done_pulse;
      rdc(STS, '0);
      chk(o_arb_table_status, 1'b0);
      wr(CTL, '0);
      chk(loads, 11);
      $display("table test done");
   endtask
   task t_reset2;
      wr(CTL, 32'h0006_0000);
      tw_pulse;
      @(posedge i_clk);
      i_reset_n <= '0;
      repeat (2) @(posedge i_clk);
      i_reset_n <= '1;
      rdc(CTL, 32'h8000_0000);
      rdc(STS, '0);
      $display("reset test done");
   endtask
   // a write of the table while disabled must be frozen out with the rest
   task t_enable;
      @(posedge i_clk);
      i_clk_en <= '0;
      i_table_write <= '1;
      @(posedge i_clk);
      i_table_write <= '0;
      @(posedge i_clk);
      chk(o_axi_arready, 1'b0);
      chk(o_arb_table_status, 1'b0);
      i_clk_en <= '1;
      rdc(STS, '0);
      $display("enable test done");
   endtask
   initial begin
      repeat (16) @(posedge i_clk);
      i_reset_n <= '1;
      t_map;
      t_table;
      t_reset2;
      t_enable;
      summarize;
   end
endmodule // tb
bind vc0_port_arb_ctl_status vc0_arb_props #(.ADDR_W(ADDR_W), .TABLE_SCHEMES(TABLE_SCHEMES))
   vc0_arb_props_inst (.i_clk, .i_reset_n, .i_clk_en, .i_axi_araddr, .i_axi_arvalid,
   .o_axi_arready, .o_axi_rdata, .o_axi_rvalid, .o_axi_bvalid, .i_table_write, .i_load_done,
   .o_load_request, .o_arb_scheme_select, .o_arb_table_status, .o_arb_table_status_valid);

// [vc0_arb_props.sv]
// port checker for the vc0 arbitration control and status block
`timescale 1ns/1ns
module vc0_arb_props
   import vc0_port_arb_pkg::*;
#(
   parameter int         ADDR_W        = 12,
   parameter logic [7:0] TABLE_SCHEMES = 8'h00
)
(
   // watched ports
   input wire logic              i_clk,
   input wire logic              i_reset_n,
   input wire logic              i_clk_en,
   input wire logic [ADDR_W-1:0] i_axi_araddr,
   input wire logic              i_axi_arvalid,
   input wire logic              o_axi_arready,
   input wire logic [31:0]       o_axi_rdata,
   input wire logic              o_axi_rvalid,
   input wire logic              o_axi_bvalid,
   input wire logic              i_table_write,
   input wire logic              i_load_done,
   input wire logic              o_load_request,
   input wire logic [2:0]        o_arb_scheme_select,
   input wire logic              o_arb_table_status,
   input wire logic              o_arb_table_status_valid
);
   logic [ADDR_W-1:0] rd_addr;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   // read data is launched from the address of the last accepted read
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) rd_addr <= '0;
      else if (i_axi_arvalid && o_axi_arready) rd_addr <= i_axi_araddr;
   end
   sequence s_answer;
      $rose(o_axi_rvalid);
   endsequence
   sequence s_write_done;
      $rose(o_axi_bvalid);
   endsequence
   a_scheme_on_write: assert property ($changed(o_arb_scheme_select) |-> $rose(o_axi_bvalid))
      else $error("scheme moved without a write");
   a_valid_map: assert property ($stable(o_arb_scheme_select) |->
      o_arb_table_status_valid == TABLE_SCHEMES[o_arb_scheme_select]) else $error("bad valid");
   a_status_set: assert property (i_table_write && i_clk_en |=> o_arb_table_status)
      else $error("table write did not set status");
   a_status_hold: assert property (o_arb_table_status && !i_load_done |=> o_arb_table_status)
      else $error("status dropped early");
   a_status_clear: assert property ($fell(o_arb_table_status) |-> $past(i_load_done))
      else $error("status cleared without load done");
   a_load_pulse: assert property (o_load_request |-> s_write_done ##1 !o_load_request)
      else $error("bad load pulse");
   a_frozen_idle: assert property (!i_clk_en |-> !o_axi_arready && !o_axi_rvalid && !o_axi_bvalid)
      else $error("handshake moved while disabled");
   a_ctl_read: assert property (s_answer ##0 rd_addr[11:2] == OFF_CONTROL[11:2] |->
      o_axi_rdata == {8'h80, 4'h0, $past(o_arb_scheme_select), 17'h0}) else $error("bad ctl");
   a_sts_read: assert property (s_answer ##0 rd_addr[11:2] == OFF_STATUS[11:2] |->
      o_axi_rdata == {15'h0, $past(o_arb_table_status), 16'h0}) else $error("bad status");
   a_cap_read: assert property (s_answer ##0 rd_addr[11:2] == OFF_CAPABILITY[11:2] |->
      o_axi_rdata == {24'h0, CAP_RESET}) else $error("bad capability");
endmodule // vc0_arb_props

// [vc0_port_arb_ctl_status.sv]
// virtual channel 0 port arbitration control and status registers behind AXI4-Lite
//
// Behaviour
// RL1 - scheme selector bits 19:17, read-write, reset zero
// RL2 - software selects only advertised schemes
// RL3 - channel identifier bits 26:24 read zero
// RL4 - channel enable bit 31 reads one
// RL5 - table write sets table status bit 16
// RL6 - status clears once requested load completes
// RL7 - status meaningful only when scheme uses table
// RL8 - negotiation pending bit 17 reads zero
// RL9 - writing one to bit 16 requests load
// RL10 - capability advertises hardware-fixed scheme, bit 0
// RL11 - reserved bits read zero, ignore writes
`timescale 1ns/1ns
module vc0_port_arb_ctl_status
   import vc0_port_arb_pkg::*;
#(
   parameter int          ADDR_W          = 12,
   // schemes (one bit per selector value) that consult the port arbitration table
   parameter logic [7:0]  TABLE_SCHEMES   = 8'h00
)
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_reset_n,
   input  wire logic              i_clk_en,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] i_axi_awaddr,
   input  wire logic              i_axi_awvalid,
   output logic                   o_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]       i_axi_wdata,
   input  wire logic [3:0]        i_axi_wstrb,
   input  wire logic              i_axi_wvalid,
   output logic                   o_axi_wready,
   // axi4-lite write response
   output logic [1:0]             o_axi_bresp,
   output logic                   o_axi_bvalid,
   input  wire logic              i_axi_bready,
   // axi4-lite read address
   input  wire logic [ADDR_W-1:0] i_axi_araddr,
   input  wire logic              i_axi_arvalid,
   output logic                   o_axi_arready,
   // axi4-lite read data
   output logic [31:0]            o_axi_rdata,
   output logic [1:0]             o_axi_rresp,
   output logic                   o_axi_rvalid,
   input  wire logic              i_axi_rready,
   // arbitration logic side
   input  wire logic              i_table_write,
   input  wire logic              i_load_done,
   output logic                   o_load_request,
   output logic [2:0]             o_arb_scheme_select,
   output logic                   o_arb_table_status,
   output logic                   o_arb_table_status_valid
);

   if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must be 10..32 to reach the register offsets");
   end

   // write path holding registers; address and data may arrive in either order
   logic              aw_held;
   logic [ADDR_W-1:0] aw_addr;
   logic              w_held;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              do_write;
   logic              wr_control;
   logic              wr_mapped;
   logic              ar_take;
   logic              rd_mapped;
   logic [31:0]       rd_value;
   logic [2:0]        arb_scheme_select;
   logic              table_status;
   logic              load_pulse;
   // registered response valids, shown only while the block is enabled
   logic              b_pending;
   logic              r_pending;

   function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [31:0] off);
      hit = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]);
   endfunction

   // readies drop while the clock enable is low so no beat is taken and lost
   assign o_axi_awready = i_clk_en & ~aw_held & ~b_pending;
   assign o_axi_wready  = i_clk_en & ~w_held & ~b_pending;
   assign o_axi_arready = i_clk_en & ~r_pending;
   // valids are masked too: a frozen slave cannot retire a response it shows
   assign o_axi_bvalid  = i_clk_en & b_pending;
   assign o_axi_rvalid  = i_clk_en & r_pending;

   assign do_write   = aw_held & w_held & ~b_pending;
   assign wr_control = hit(aw_addr, OFF_CONTROL);
   assign wr_mapped  = wr_control | hit(aw_addr, OFF_STATUS) | hit(aw_addr, OFF_CAPABILITY);
   assign ar_take    = i_axi_arvalid & o_axi_arready;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
      end else if (i_clk_en) begin
         if (i_axi_awvalid && o_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= i_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (i_clk_en) begin
         if (i_axi_wvalid && o_axi_wready) begin
            w_held <= 1'b1;
            w_data <= i_axi_wdata;
            w_strb <= i_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         b_pending   <= 1'b0;
         o_axi_bresp <= RESP_OKAY;
      end else if (i_clk_en) begin
         if (do_write) begin
            b_pending   <= 1'b1;
            o_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (i_axi_bready) begin
            b_pending   <= 1'b0;
         end
      end
   end

   // scheme selector is stored as written; an unadvertised value is software's fault
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         arb_scheme_select <= SCHEME_RESET;                              // [RL1]
      end else if (i_clk_en) begin
         if (do_write && wr_control && w_strb[CTL_FIELD_LANE]) begin
            arb_scheme_select <= w_data[CTL_SCHEME_LSB +: CTL_SCHEME_W]; // [RL1] [RL2]
         end
      end
   end

   // only a written one requests a load; the bit itself is never stored
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         load_pulse <= 1'b0;
      end else if (i_clk_en) begin
         load_pulse <= do_write & wr_control & w_strb[CTL_FIELD_LANE]
                       & w_data[CTL_LOAD_BIT];                           // [RL9]
      end
   end

   // the flag is kept for every scheme; only the valid output tells when it counts
   arb_table_tracker u_tracker (
      .i_clk          (i_clk),
      .i_reset_n      (i_reset_n),
      .i_clk_en       (i_clk_en),
      .i_table_write  (i_table_write),
      .i_load_request (load_pulse),
      .i_load_done    (i_load_done),
      .o_table_status (table_status)
   );

   always_comb begin
      rd_value  = 32'h0000_0000;                                         // [RL11]
      rd_mapped = 1'b1;
      if (hit(i_axi_araddr, OFF_CAPABILITY)) begin
         rd_value[CAP_W-1:0] = CAP_RESET;                                // [RL10]
      end else if (hit(i_axi_araddr, OFF_CONTROL)) begin
         rd_value[CTL_LOAD_BIT]                       = 1'b0;            // [RL9]
         rd_value[CTL_SCHEME_LSB +: CTL_SCHEME_W]     = arb_scheme_select; // [RL1]
         rd_value[CTL_CHANNEL_LSB +: CTL_CHANNEL_W]   = CHANNEL_ID_VALUE;  // [RL3]
         rd_value[CTL_ENABLE_BIT]                     = CHANNEL_EN_VALUE;  // [RL4]
      end else if (hit(i_axi_araddr, OFF_STATUS)) begin
         rd_value[STS_TABLE_BIT] = table_status;                         // [RL5] [RL6]
         rd_value[STS_NEG_BIT]   = NEG_PENDING_VALUE;                    // [RL8]
      end else begin
         rd_mapped = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         r_pending   <= 1'b0;
         o_axi_rdata <= 32'h0000_0000;
         o_axi_rresp <= RESP_OKAY;
      end else if (i_clk_en) begin
         if (ar_take) begin
            r_pending   <= 1'b1;
            o_axi_rdata <= rd_value;
            o_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (i_axi_rready) begin
            r_pending   <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         // follows the reset scheme, so the flag is right from the first cycle
         o_arb_table_status_valid <= TABLE_SCHEMES[SCHEME_RESET];        // [RL7]
      end else if (i_clk_en) begin
         o_arb_table_status_valid <= TABLE_SCHEMES[arb_scheme_select];   // [RL7]
      end
   end

   assign o_load_request      = load_pulse;
   assign o_arb_scheme_select = arb_scheme_select;
   assign o_arb_table_status  = table_status;

endmodule // vc0_port_arb_ctl_status

// [vc0_port_arb_pkg.sv]
// constants for the virtual channel 0 port arbitration control and status block
package vc0_port_arb_pkg;

   // register byte offsets
   localparam logic [31:0] OFF_CAPABILITY    = 32'h0000_0210;
   localparam logic [31:0] OFF_CONTROL       = 32'h0000_0214;
   localparam logic [31:0] OFF_STATUS        = 32'h0000_0218;

   // control register fields
   localparam int          CTL_LOAD_BIT      = 16;
   localparam int          CTL_SCHEME_LSB    = 17;
   localparam int          CTL_SCHEME_W      = 3;
   localparam int          CTL_CHANNEL_LSB   = 24;
   localparam int          CTL_CHANNEL_W     = 3;
   localparam int          CTL_ENABLE_BIT    = 31;
   localparam logic [2:0]  SCHEME_RESET      = 3'h0;
   localparam logic [2:0]  CHANNEL_ID_VALUE  = 3'h0;
   localparam logic        CHANNEL_EN_VALUE  = 1'h1;

   // status register fields
   localparam int          STS_TABLE_BIT     = 16;
   localparam int          STS_NEG_BIT       = 17;
   localparam logic        NEG_PENDING_VALUE = 1'h0;

   // capability field: one bit per scheme, only the hardware-fixed scheme
   localparam int          CAP_W             = 8;
   localparam logic [7:0]  CAP_RESET         = 8'h01;

   // byte lane that carries control bits 23:16
   localparam int          CTL_FIELD_LANE    = 2;

   // bus answers
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;

   // table coherency tracker states
   typedef enum logic [2:0] {
      TBL_CLEAN   = 3'b001,
      TBL_DIRTY   = 3'b010,
      TBL_LOADING = 3'b100
   } table_state_e;

endpackage
